// ### src/input_pll_divider_pump_control.sv
`default_nettype none
module input_pll_divider_pump_control (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic reg_write,
  input wire logic [input_loop_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [input_loop_pkg::DATA_W-1:0] reg_wdata,
  output logic [input_loop_pkg::DATA_W-1:0] reg_rdata,
  input wire logic readback_buffer,
  input wire logic io_update,
  input wire logic ref_b_independent,
  input wire logic ref_a_tick,
  input wire logic ref_b_tick,
  input wire logic ref_test_tick,
  input wire logic feedback_tick,
  output logic ref_a_pulse,
  output logic ref_b_pulse,
  output logic ref_test_pulse,
  output logic feedback_pulse,
  output logic pump_tristate,
  output logic [input_loop_pkg::CURRENT_W-1:0] pump_current,
  output input_loop_pkg::pump_mode_t pump_mode,
  output input_loop_pkg::backlash_t backlash_width
);
  import input_loop_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  // Helpers

  // Writable bit mask of a register index
  function automatic logic [DATA_W-1:0] reg_mask(input int idx);
    unique case (idx)
      IDX_REF_A_HIGH, IDX_REF_B_HIGH, IDX_FB_HIGH: reg_mask = MASK_HIGH_PAIR;
      IDX_REF_TEST: reg_mask = MASK_TEST;
      IDX_SPARE: reg_mask = MASK_NONE;
      IDX_PUMP_MODE: reg_mask = MASK_MODE;
      default: reg_mask = MASK_FULL;
    endcase
  endfunction : reg_mask

  // Value after reset of a register index
  function automatic logic [DATA_W-1:0] reg_reset(input int idx);
    unique case (idx)
      IDX_PUMP_CURRENT: reg_reset = RST_PUMP_CURRENT;
      IDX_PUMP_MODE: reg_reset = RST_PUMP_MODE;
      default: reg_reset = RST_DIVIDE;
    endcase
  endfunction : reg_reset

  // Effective ratio: zero and one both divide by one
  function automatic logic [RATIO_W-1:0] eff_ratio(input logic [RATIO_W-1:0] r);
    eff_ratio = (r < RST_COUNT) ? RST_COUNT : r;
  endfunction : eff_ratio

  ////////////////////////////////////////////////////////////////////////
  // Shadow and active register banks

  logic [DATA_W-1:0] shadow [NUM_REGS]; // Written by software
  logic [DATA_W-1:0] active [NUM_REGS]; // Applied to the logic
  logic [DATA_W-1:0] next_shadow [NUM_REGS];
  logic [DATA_W-1:0] next_active [NUM_REGS];
  logic [DATA_W-1:0] next_reg_rdata;

  // Write decode, update transfer and readback select
  always_comb begin
    next_reg_rdata = RST_READ;
    for (int i = 0; i < NUM_REGS; i++) begin
      next_shadow[i] = shadow[i];
      // Only writable bits store; reserved stay zero
      if (reg_write && reg_addr == REF_A_DIVIDE_LOW + ADDR_W'(i)) begin
        next_shadow[i] = reg_wdata & reg_mask(i);
      end
      // Update copies the buffer, including a write in the same cycle
      next_active[i] = io_update ? next_shadow[i] : active[i];
      // Readback from buffer or active copy
      if (reg_addr == REF_A_DIVIDE_LOW + ADDR_W'(i)) begin
        next_reg_rdata = readback_buffer ? shadow[i] : active[i];
      end
    end
  end

  // Register banks
  always_ff @(posedge clock) begin
    for (int i = 0; i < NUM_REGS; i++) begin
      if (!rst_b) begin
        shadow[i] <= reg_reset(i);
        active[i] <= reg_reset(i);
      end else begin
        shadow[i] <= next_shadow[i];
        active[i] <= next_active[i];
      end
    end
    if (!rst_b) begin
      reg_rdata <= RST_READ;
    end else begin
      reg_rdata <= next_reg_rdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Ratio assembly

  logic [RATIO_W-1:0] ratio [NUM_DIVS]; // Effective divide ratios
  logic [NUM_DIVS-1:0] tick; // Input clock ticks per channel

  // Join low and high halves of each ratio; the test ratio is one register alone
  always_comb begin
    ratio[DIV_REF_A] = eff_ratio({active[IDX_REF_A_HIGH][1:0],
                                  active[IDX_REF_A_LOW]});
    // Follows the first ratio unless set independent
    if (ref_b_independent) begin
      ratio[DIV_REF_B] = eff_ratio({active[IDX_REF_B_HIGH][1:0],
                                    active[IDX_REF_B_LOW]});
    end else begin
      ratio[DIV_REF_B] = ratio[DIV_REF_A];
    end
    ratio[DIV_REF_TEST] = eff_ratio({4'h0,
                                     active[IDX_REF_TEST][TEST_RATIO_W-1:0]});
    ratio[DIV_FEEDBACK] = eff_ratio({active[IDX_FB_HIGH][1:0],
                                     active[IDX_FB_LOW]});
    tick = {feedback_tick, ref_test_tick, ref_b_tick, ref_a_tick};
  end

  ////////////////////////////////////////////////////////////////////////
  // Divider counters

  logic [RATIO_W-1:0] count [NUM_DIVS]; // One more than the ticks seen in this period
  logic [RATIO_W-1:0] next_count [NUM_DIVS];
  logic [NUM_DIVS-1:0] pulse; // Registered divider outputs
  logic [NUM_DIVS-1:0] next_pulse;

  // Count ticks; pulse and reload at the ratio
  always_comb begin
    for (int k = 0; k < NUM_DIVS; k++) begin
      next_count[k] = count[k];
      next_pulse[k] = 1'b0;
      if (tick[k]) begin
        // Terminal tick, or ratio lowered below count
        if (count[k] >= ratio[k]) begin
          next_count[k] = RST_COUNT;
          next_pulse[k] = 1'b1;
        end else begin
          next_count[k] = count[k] + RST_COUNT;
        end
      end
    end
  end

  // Counter registers
  always_ff @(posedge clock) begin
    for (int k = 0; k < NUM_DIVS; k++) begin
      if (!rst_b) begin
        count[k] <= RST_COUNT;
        pulse[k] <= 1'b0;
      end else begin
        count[k] <= next_count[k];
        pulse[k] <= next_pulse[k];
      end
    end
  end

  // Pulse outputs straight from flip-flops
  always_comb begin
    ref_a_pulse = pulse[DIV_REF_A];
    ref_b_pulse = pulse[DIV_REF_B];
    ref_test_pulse = pulse[DIV_REF_TEST];
    feedback_pulse = pulse[DIV_FEEDBACK];
  end

  ////////////////////////////////////////////////////////////////////////
  // Charge pump and antibacklash controls

  logic next_pump_tristate;
  logic [CURRENT_W-1:0] next_pump_current;
  pump_mode_t next_pump_mode;
  backlash_t next_backlash_width;

  // Decode the two pump registers
  always_comb begin
    next_pump_mode = pump_mode_t'(active[IDX_PUMP_MODE][MODE_LSB +: 2]);
    // Off when forced, or in tristate mode
    next_pump_tristate = active[IDX_PUMP_CURRENT][TRISTATE_BIT] ||
                         (next_pump_mode == PUMP_TRISTATE);
    next_pump_current = active[IDX_PUMP_CURRENT][CURRENT_W-1:0];
    // Width field only counts under override
    if (active[IDX_PUMP_MODE][OVERRIDE_BIT]) begin
      next_backlash_width = backlash_t'(active[IDX_PUMP_MODE][WIDTH_LSB +: 2]);
    end else begin
      next_backlash_width = BACKLASH_HIGH;
    end
  end

  // Pump control registers
  always_ff @(posedge clock) begin
    if (!rst_b) begin
      pump_tristate <= 1'b1;
      pump_current <= RST_PUMP_CURRENT[CURRENT_W-1:0];
      pump_mode <= PUMP_TRISTATE;
      backlash_width <= BACKLASH_HIGH;
    end else begin
      pump_tristate <= next_pump_tristate;
      pump_current <= next_pump_current;
      pump_mode <= next_pump_mode;
      backlash_width <= next_backlash_width;
    end
  end
endmodule : input_pll_divider_pump_control
`default_nettype wire

// ### src/input_loop_pkg.sv
`default_nettype none
package input_loop_pkg;
  // Register port and field widths, register and divider counts
  localparam int ADDR_W = 10;
  localparam int DATA_W = 8;
  localparam int RATIO_W = 10;
  localparam int TEST_RATIO_W = 6;
  localparam int CURRENT_W = 7;
  localparam int NUM_REGS = 10;
  localparam int NUM_DIVS = 4;

  // Register offsets
  localparam logic [ADDR_W-1:0] REF_A_DIVIDE_LOW = 10'h010;
  localparam logic [ADDR_W-1:0] REF_A_DIVIDE_HIGH = 10'h011;
  localparam logic [ADDR_W-1:0] REF_B_DIVIDE_LOW = 10'h012;
  localparam logic [ADDR_W-1:0] REF_B_DIVIDE_HIGH = 10'h013;
  localparam logic [ADDR_W-1:0] REF_TEST_DIVIDE = 10'h014;
  localparam logic [ADDR_W-1:0] INPUT_PLL_SPARE = 10'h015;
  localparam logic [ADDR_W-1:0] FEEDBACK_DIVIDE_LOW = 10'h016;
  localparam logic [ADDR_W-1:0] FEEDBACK_DIVIDE_HIGH = 10'h017;
  localparam logic [ADDR_W-1:0] PUMP_CURRENT_TRISTATE = 10'h018;
  localparam logic [ADDR_W-1:0] PUMP_MODE_BACKLASH = 10'h019;

  // Register indices, counted from the first offset
  localparam int IDX_REF_A_LOW = 0;
  localparam int IDX_REF_A_HIGH = 1;
  localparam int IDX_REF_B_LOW = 2;
  localparam int IDX_REF_B_HIGH = 3;
  localparam int IDX_REF_TEST = 4;
  localparam int IDX_SPARE = 5;
  localparam int IDX_FB_LOW = 6;
  localparam int IDX_FB_HIGH = 7;
  localparam int IDX_PUMP_CURRENT = 8;
  localparam int IDX_PUMP_MODE = 9;

  // Divider channel numbers
  localparam int DIV_REF_A = 0;
  localparam int DIV_REF_B = 1;
  localparam int DIV_REF_TEST = 2;
  localparam int DIV_FEEDBACK = 3;

  // Writable bits of each register; the rest read as zero
  localparam logic [DATA_W-1:0] MASK_FULL = 8'hff;
  localparam logic [DATA_W-1:0] MASK_HIGH_PAIR = 8'h03;
  localparam logic [DATA_W-1:0] MASK_TEST = 8'h3f;
  localparam logic [DATA_W-1:0] MASK_NONE = 8'h00;
  localparam logic [DATA_W-1:0] MASK_MODE = 8'h1f;

  // Field positions
  localparam int TRISTATE_BIT = 7;
  localparam int OVERRIDE_BIT = 4;
  localparam int WIDTH_LSB = 2;
  localparam int MODE_LSB = 0;

  // Values after reset
  localparam logic [DATA_W-1:0] RST_DIVIDE = 8'h00;
  localparam logic [DATA_W-1:0] RST_PUMP_CURRENT = 8'h00;
  localparam logic [DATA_W-1:0] RST_PUMP_MODE = 8'h08;
  localparam logic [RATIO_W-1:0] RST_COUNT = 10'h001;
  localparam logic [DATA_W-1:0] RST_READ = 8'h00;

  // Antibacklash period encodings
  typedef enum logic [1:0] {
    BACKLASH_MIN = 2'h0,
    BACKLASH_LOW = 2'h1,
    BACKLASH_HIGH = 2'h2,
    BACKLASH_MAX = 2'h3
  } backlash_t;

  // Charge pump modes
  typedef enum logic [1:0] {
    PUMP_TRISTATE = 2'h0,
    PUMP_UP = 2'h1,
    PUMP_DOWN = 2'h2,
    PUMP_NORMAL = 2'h3
  } pump_mode_t;
endpackage : input_loop_pkg
`default_nettype wire

// ### bench/input_loop_checker.sv
`default_nettype none
module input_loop_checker (
  input wire logic clock,
  input wire logic rst_b,
  input wire logic reg_write,
  input wire logic [input_loop_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [input_loop_pkg::DATA_W-1:0] reg_wdata,
  input wire logic [input_loop_pkg::DATA_W-1:0] reg_rdata,
  input wire logic readback_buffer,
  input wire logic io_update,
  input wire logic ref_a_tick,
  input wire logic ref_b_tick,
  input wire logic ref_test_tick,
  input wire logic feedback_tick,
  input wire logic ref_a_pulse,
  input wire logic ref_b_pulse,
  input wire logic ref_test_pulse,
  input wire logic feedback_pulse,
  input wire logic pump_tristate,
  input wire logic [input_loop_pkg::CURRENT_W-1:0] pump_current,
  input wire input_loop_pkg::pump_mode_t pump_mode,
  input wire input_loop_pkg::backlash_t backlash_width
);
  timeunit 1ns;
  timeprecision 1ps;
  import input_loop_pkg::*;
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_b);
  // One byte written, then applied alone on the next edge
  sequence s_commit(a);
    reg_write && reg_addr == a ##1 io_update && !reg_write;
  endsequence
  // Test ratio written, then looked at through the shadow
  sequence s_shadow_look;
    reg_write && reg_addr == REF_TEST_DIVIDE ##1
    !reg_write && readback_buffer && reg_addr == REF_TEST_DIVIDE;
  endsequence
  a_shadow_read: assert property (s_shadow_look |=>
    reg_rdata == ($past(reg_wdata, 2) & 8'h3f)) else $error("shadow readback wrong");
  a_unmapped_zero: assert property (reg_addr < REF_A_DIVIDE_LOW || reg_addr > PUMP_MODE_BACKLASH
    || reg_addr == INPUT_PLL_SPARE |=> reg_rdata == 8'h00) else $error("reserved read not zero");
  a_current_apply: assert property (s_commit(PUMP_CURRENT_TRISTATE) |=> ##1
    {1'b0, pump_current} == ($past(reg_wdata, 3) & 8'h7f) && pump_tristate ==
    ($past(reg_wdata, 3) >= 8'h80 || pump_mode == PUMP_TRISTATE)) else $error("pump current wrong");
  a_mode_apply: assert property (s_commit(PUMP_MODE_BACKLASH) |=> ##1
    {6'h00, pump_mode} == ($past(reg_wdata, 3) & 8'h03)) else $error("pump mode wrong");
  a_backlash_forced: assert property (s_commit(PUMP_MODE_BACKLASH) |=> ##1
    (($past(reg_wdata, 3) & 8'h10) == 8'h00 ? backlash_width == BACKLASH_HIGH :
    {6'h00, backlash_width} == (($past(reg_wdata, 3) >> 2) & 8'h03))) else $error("backlash wrong");
  a_outputs_hold: assert property (!io_update [*2] |=> $stable(pump_current)
    && $stable(pump_mode) && $stable(backlash_width) && $stable(pump_tristate))
    else $error("control moved without update");
  a_mode_tristate: assert property (pump_mode == PUMP_TRISTATE |-> pump_tristate)
    else $error("tristate mode leaves pump on");
  a_pulse_cause: assert property ((ref_a_pulse |-> $past(ref_a_tick)) and
    (ref_b_pulse |-> $past(ref_b_tick)) and (ref_test_pulse |-> $past(ref_test_tick)) and
    (feedback_pulse |-> $past(feedback_tick))) else $error("pulse without tick");
endmodule : input_loop_checker
bind input_pll_divider_pump_control input_loop_checker input_loop_checker_i (.clock, .rst_b,
  .reg_write, .reg_addr, .reg_wdata, .reg_rdata, .readback_buffer, .io_update, .ref_a_tick,
  .ref_b_tick, .ref_test_tick, .feedback_tick, .ref_a_pulse, .ref_b_pulse, .ref_test_pulse,
  .feedback_pulse, .pump_tristate, .pump_current, .pump_mode, .backlash_width);
`default_nettype wire

// ### bench/tb_top.sv
`default_nettype none
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import input_loop_pkg::*;
  logic clock = 0, rst_b = 0, reg_write = 0, readback_buffer = 0, io_update = 0;
  logic ref_b_independent = 0, rd_now = 0, rd_prev = 0, pl_now = 0, pl_prev = 0;
  logic [ADDR_W-1:0] reg_addr = '0;
  logic [DATA_W-1:0] reg_wdata = '0, reg_rdata, shadow [NUM_REGS], active [NUM_REGS];
  logic [DATA_W-1:0] mask [NUM_REGS] = '{8'hff, 8'h03, 8'hff, 8'h03, 8'h3f, 8'h00, 8'hff,
    8'h03, 8'hff, 8'h1f}; // Writable bits per register
  logic [3:0] tick = '0;
  wire [3:0] pulse;
  logic pump_tristate;
  logic [CURRENT_W-1:0] pump_current;
  pump_mode_t pump_mode;
  backlash_t backlash_width;
  logic [DATA_W-1:0] rd_q [$]; // Expected read bytes
  logic [3:0] pl_q [$]; // Expected pulse vectors
  int cnt [4], fails = 0, cmp_count = 0, seed = 32'h3d51_7b62;
  input_pll_divider_pump_control input_pll_divider_pump_control_i (
    .clock, .rst_b, .reg_write, .reg_addr, .reg_wdata, .reg_rdata, .readback_buffer,
    .io_update, .ref_b_independent, .ref_a_tick(tick[0]), .ref_b_tick(tick[1]),
    .ref_test_tick(tick[2]), .feedback_tick(tick[3]), .ref_a_pulse(pulse[0]),
    .ref_b_pulse(pulse[1]), .ref_test_pulse(pulse[2]), .feedback_pulse(pulse[3]),
    .pump_tristate, .pump_current, .pump_mode, .backlash_width);
  always #5 clock = ~clock;
  ////////////////////////////////////////////////////////////////////////////////
  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: got %h, wanted %h", $time, got, exp);
    end
  endtask : check
  // Divider pulse vector against its note
  task automatic check_pulse(input logic [3:0] got, input logic [3:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: pulses %b, wanted %b", $time, got, exp);
    end
  endtask : check_pulse
  // Oldest note against the result that shows this edge
  always @(posedge clock) begin
    if (rd_prev) check(reg_rdata, rd_q.pop_front());
    if (pl_prev) check_pulse(pulse, pl_q.pop_front());
    rd_prev <= rd_now;
    pl_prev <= pl_now;
  end
  ////////////////////////////////////////////////////////////////////////////////
  // Active ratio seen by divider k; second follows first unless independent
  function automatic int ratio(input int k);
    int b;
    b = (k == 1 && !ref_b_independent) ? 0 : 2 * k;
    if (k == 2) return active[4];
    return {active[b + 1][1:0], active[b]};
  endfunction : ratio
  task automatic reset_dut();
    rst_b = 0;
    repeat (8) @(negedge clock);
    shadow = '{default: 8'h00};
    shadow[9] = 8'h08; // High backlash width after reset
    active = shadow;
    cnt = '{default: 1};
    rst_b = 1;
  endtask : reset_dut
  task automatic wr(input int i, input logic [7:0] d);
    @(negedge clock);
    reg_write = 1;
    reg_addr = ADDR_W'(16 + i);
    reg_wdata = d;
    if (i >= 0 && i < NUM_REGS) shadow[i] = d & mask[i];
    @(negedge clock);
    reg_write = 0;
  endtask : wr
  task automatic rd(input int i);
    @(negedge clock);
    reg_addr = ADDR_W'(16 + i);
    rd_now = 1;
    rd_q.push_back((i < 0 || i >= NUM_REGS) ? 8'h00 : readback_buffer ? shadow[i] : active[i]);
    @(negedge clock);
    rd_now = 0;
  endtask : rd
  task automatic upd();
    io_update = 1;
    active = shadow;
    @(negedge clock);
    io_update = 0;
  endtask : upd
  // Random ticks; each counter pulses on its ratio-th tick
  task automatic ticks(input int n);
    logic [3:0] e;
    repeat (n) begin
      @(negedge clock);
      tick = 4'($random(seed));
      for (int k = 0; k < 4; k++) begin
        e[k] = tick[k] && cnt[k] >= ratio(k);
        if (tick[k]) cnt[k] = e[k] ? 1 : cnt[k] + 1;
      end
      pl_q.push_back(e);
      pl_now = 1;
    end
    @(negedge clock);
    tick = 0;
    pl_now = 0;
  endtask : ticks
  task automatic final_report();
    $display("comparisons %0d, mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : final_report
  ////////////////////////////////////////////////////////////////////////////////
  // Rounds of random writes, shadow and active reads, update, ticks
  initial begin
    reset_dut();
    for (int r = 0; r < 8; r++) begin
      if (r == 4) reset_dut();
      ref_b_independent = r[1];
      readback_buffer = 1;
      for (int i = -1; i <= NUM_REGS; i++) wr(i, 8'($random(seed)) & (r < 4 ? 8'h07 : 8'hff));
      for (int b = 1; b >= 0; b--) begin
        readback_buffer = b[0];
        for (int i = -1; i <= NUM_REGS; i++) rd(i);
      end
      wr(8 + r % 2, 8'($random(seed)));
      upd();
      for (int i = 0; i < NUM_REGS; i++) rd(i);
      ticks(60);
    end
    final_report();
  end
  // Hang guard
  initial begin
    #100us;
    fails++;
    final_report();
  end
endmodule : tb_top
`default_nettype wire
